//--- hw/sysclk_pkg.sv
// package for the system clock and operating mode controller
// assumes one 100 MHz system clock and a plain register port
package sysclk_pkg;
	// **************************************************
	// register offsets on the 2-bit register port
	// **************************************************
	localparam logic [1:0] SYSCTL_ONE_ADDR = 2'h0; // system_control_one
	localparam logic [1:0] SYSCTL_TWO_ADDR = 2'h1; // system_control_two
	localparam logic [1:0] BT_CTRL_ADDR = 2'h2; // base_timer_control
	localparam logic [1:0] STATUS_ADDR = 2'h3; // read-only status
	// **************************************************
	// field positions
	// **************************************************
	localparam int STOP_BIT = 7; // system_control_one: stop request
	localparam int RELM_BIT = 6; // system_control_one: level release
	localparam int SLOW_EN_BIT = 6; // system_control_two: slow osc on
	localparam int MAIN_CLOCK_SELECT_BIT = 5; // main_clock_select
	localparam int IDLE_BIT = 4; // wait request
	localparam int HALT_BIT = 2; // timing_gen_halt_request
	localparam int DIVIDER_STAGE_SEVEN_SOURCE_BIT = 7; // divider_stage_seven_source
	localparam int BASE_TIMER_ENABLE_BIT_BIT = 3; // base_timer_enable_bit
	// **************************************************
	// reset values and counts
	// **************************************************
	localparam logic [7:0] CTRL_RESET = 8'h00; // control bits after reset
	localparam logic [1:0] PRE_RESET = 2'h0; // prescaler after reset
	localparam logic [20:0] DIV_RESET = 21'h00000; // divider reset
	localparam logic [1:0] LAST_STATE = 2'h3; // S3 ends a machine cycle
	localparam logic [3:0] MAX_CYCLES = 4'ha; // longest instruction
	localparam logic [4:0] BT_TAP_BASE = 5'h08; // lowest base timer tap
	// **************************************************
	// operating modes
	// **************************************************
	typedef enum logic [2:0] {
		single_clock_run,
		single_clock_wait,
		single_clock_halt,
		dual_clock_fast_run,
		dual_clock_fast_wait,
		slow_dual_run,
		stop_hold,
		stop_warm_up
	} mode_type;
	// register port request bundle
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;
endpackage

//--- hw/system_clock_mode_controller.sv
// system clock controller: prescaler, divider, machine cycle
// timing and the operating mode machine
// assumes fast and slow oscillator levels arrive as pins and the
// cpu and interrupt logic share i_mclk
//
// Functional notes
// - two-stage prescaler then twenty-one-stage divider
// - prescaler, divider cleared on reset and stop
// - stage seven input chosen by mode, bits
// - slow modes feed slow clock to stage seven
// - fast stop warm-up feeds stage six output
// - machine cycle is four states S0-S3
// - instructions last one to ten machine cycles
// - mode machine drives oscillators and clock switch
// - single-clock: fast osc only, slow pins ports
// - reset enters single clock run mode
// - wait request halts cpu until interrupt
// - wake services interrupt or resumes next instruction
// - halt gates all clocks but base timer
// - selected tap falling edge ends halt mode
// - halt exit service needs three enables set
// - halt entered with timer enabled sets latch
// - dual-clock: both oscillators, slow main clock option
// - dual fast run: cpu fast, peripherals either
// - main clock select moves fast/slow dual run
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module system_clock_mode_controller
	import sysclk_pkg::*;
#(
	parameter logic [14:0] WARM_UP_TICKS = 15'h0100 // stage-7 ticks
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire bus_req_type i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_fast_osc_input,
	input wire logic i_slow_osc_input,
	input wire logic i_stop_pin,
	input wire logic i_irq_request,
	input wire logic i_interrupt_master_enable,
	input wire logic i_base_timer_irq_enable,
	input wire logic i_instr_start,
	input wire logic [3:0] i_instr_cycles,
	output logic o_fast_osc_output,
	output logic o_slow_osc_output,
	output logic o_slow_pins_are_ports,
	output logic o_cpu_clk_en,
	output logic o_periph_clk_en,
	output logic o_base_timer_clk_en,
	output logic [1:0] o_machine_state,
	output logic o_instr_done,
	output logic [20:0] o_divider,
	output logic o_wake_service,
	output logic o_wake_resume,
	output logic o_base_timer_irq_latch,
	output logic o_base_timer_irq_service
);
	// **************************************************
	// helpers
	// **************************************************
	// clamp an instruction length into the legal one..ten range
	function automatic logic [3:0] clamp_cycles(input logic [3:0] n);
		if (n == 4'h0) begin
			return 4'h1;
		end
		return (n > MAX_CYCLES) ? MAX_CYCLES : n;
	endfunction

	// true for the modes where the cpu fetches instructions
	function automatic logic is_run(input mode_type m);
		return m == single_clock_run || m == dual_clock_fast_run ||
			m == slow_dual_run;
	endfunction

	// **************************************************
	// pin synchronisers
	// **************************************************
	logic [1:0] fast_sync_reg; // fast oscillator level, two flops
	logic [1:0] slow_sync_reg; // slow oscillator level
	logic [1:0] stop_sync_reg; // stop release pin
	logic fast_prev_reg; // last synced fast level
	logic slow_prev_reg; // last synced slow level
	logic stop_prev_reg; // last synced stop pin level

	// only bit 1 of each synchroniser is read by logic
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			fast_sync_reg <= 2'h0;
			slow_sync_reg <= 2'h0;
			stop_sync_reg <= 2'h0;
			fast_prev_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
			stop_prev_reg <= 1'b0;
		end else if (i_ce) begin
			fast_sync_reg <= {fast_sync_reg[0], i_fast_osc_input};
			slow_sync_reg <= {slow_sync_reg[0], i_slow_osc_input};
			stop_sync_reg <= {stop_sync_reg[0], i_stop_pin};
			fast_prev_reg <= fast_sync_reg[1];
			slow_prev_reg <= slow_sync_reg[1];
			stop_prev_reg <= stop_sync_reg[1];
		end
	end

	// **************************************************
	// registers
	// **************************************************
	mode_type mode_reg; // current operating mode
	logic [7:0] sysctl_one_reg; // stop request, release method
	logic [7:0] sysctl_two_reg; // slow enable, clock select, requests
	logic [7:0] bt_ctrl_reg; // stage-7 source, timer enable, tap
	logic [7:0] rdata_reg; // read data, valid one cycle after strobe
	logic wr_one;
	logic wr_two;
	logic consume; // request bits are acted on in run modes

	assign wr_one = i_bus.wr && i_bus.addr == SYSCTL_ONE_ADDR;
	assign wr_two = i_bus.wr && i_bus.addr == SYSCTL_TWO_ADDR;
	assign consume = is_run(mode_reg);

	// control writes; request bits self clear in any run mode, acted on or not, but a
	// write in the same cycle wins so no request is lost
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sysctl_one_reg <= CTRL_RESET;
			sysctl_two_reg <= CTRL_RESET;
			bt_ctrl_reg <= CTRL_RESET;
		end else if (i_ce) begin
			if (wr_one) begin
				sysctl_one_reg <= i_bus.wdata;
			end else if (consume) begin
				sysctl_one_reg[STOP_BIT] <= 1'b0;
			end
			if (wr_two) begin
				sysctl_two_reg <= i_bus.wdata;
			end else if (consume) begin
				sysctl_two_reg[IDLE_BIT] <= 1'b0;
				sysctl_two_reg[HALT_BIT] <= 1'b0;
			end
			if (i_bus.wr && i_bus.addr == BT_CTRL_ADDR) begin
				bt_ctrl_reg <= i_bus.wdata;
			end
		end
	end

	// register read: cycles without a read strobe read zero, status shows the mode
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else if (i_ce) begin
			rdata_reg <= 8'h00;
			if (i_bus.rd) begin
				unique case (i_bus.addr)
					SYSCTL_ONE_ADDR: rdata_reg <= sysctl_one_reg;
					SYSCTL_TWO_ADDR: rdata_reg <= sysctl_two_reg;
					BT_CTRL_ADDR: rdata_reg <= bt_ctrl_reg;
					STATUS_ADDR: rdata_reg <= {5'h00, mode_reg};
				endcase
			end
		end
	end
	assign o_rdata = rdata_reg;

	// **************************************************
	// clock ticks and divider chain
	// **************************************************
	logic slow_en; // slow oscillator requested
	logic fast_on; // fast oscillator running (off in stop hold only)
	logic fast_tick; // one rising edge of the fast clock
	logic slow_tick; // one rising edge of the slow clock
	logic slow_mode;
	logic warm_fast_reg; // stop was entered from a fast mode
	logic [1:0] pre_reg; // two-stage prescaler
	logic [20:0] div_reg; // stages 1..21
	logic pre_wrap;
	logic carry6; // stage six output into stage seven
	logic st7_tick; // stage seven input
	logic div_clear;
	logic stop_release;

	assign slow_en = sysctl_two_reg[SLOW_EN_BIT];
	assign fast_on = mode_reg != stop_hold;
	assign fast_tick = fast_on && fast_sync_reg[1] && !fast_prev_reg;
	assign slow_tick = slow_en && slow_sync_reg[1] && !slow_prev_reg;
	assign slow_mode = mode_reg == slow_dual_run;
	assign pre_wrap = fast_tick && pre_reg == 2'h3;
	assign carry6 = pre_wrap && div_reg[5:0] == 6'h3f;

	// stage seven source: slow modes force the slow clock, a warm-up
	// after a fast stop forces stage six, else the source bit decides
	always_comb begin
		if (slow_mode) begin
			st7_tick = slow_tick;
		end else if (mode_reg == stop_warm_up && warm_fast_reg) begin
			st7_tick = carry6;
		end else if (bt_ctrl_reg[DIVIDER_STAGE_SEVEN_SOURCE_BIT]) begin
			st7_tick = slow_tick;
		end else begin
			st7_tick = carry6;
		end
	end

	// stop pin release: level or edge as the release method bit says
	assign stop_release = sysctl_one_reg[RELM_BIT] ? stop_sync_reg[1] :
		(stop_sync_reg[1] && !stop_prev_reg);
	assign div_clear = (consume && sysctl_one_reg[STOP_BIT]) ||
		(mode_reg == stop_hold && stop_release);

	// prescaler and divider; cleared on entry into stop and on release from stop hold
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pre_reg <= PRE_RESET;
			div_reg <= DIV_RESET;
		end else if (i_ce) begin
			if (div_clear) begin
				pre_reg <= PRE_RESET;
				div_reg <= DIV_RESET;
			end else begin
				if (fast_tick) begin
					pre_reg <= pre_reg + 2'h1;
				end
				if (pre_wrap) begin
					div_reg[5:0] <= div_reg[5:0] + 6'h01;
				end
				if (st7_tick) begin
					div_reg[20:6] <= div_reg[20:6] + 15'h0001;
				end
			end
		end
	end
	assign o_divider = div_reg;

	// **************************************************
	// main clock select and machine cycle
	// **************************************************
	logic sel_slow_reg; // main clock now from the slow clock
	logic main_tick; // one main system clock period
	logic [1:0] state_reg; // S0..S3
	logic cycle_end;
	logic [3:0] left_reg; // machine cycles left in the instruction
	logic done_reg;

	assign main_tick = sel_slow_reg ? slow_tick : fast_tick;
	assign cycle_end = main_tick && state_reg == LAST_STATE;

	// source changes only at the end of S3 so no state is cut short
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sel_slow_reg <= 1'b0;
		end else if (i_ce && cycle_end) begin
			sel_slow_reg <= slow_mode;
		end
	end

	// four states per machine cycle, each one main clock long
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg <= 2'h0;
		end else if (i_ce && main_tick) begin
			state_reg <= state_reg + 2'h1;
		end
	end
	assign o_machine_state = state_reg;

	// instruction length counter: pulses done at its last cycle end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			left_reg <= 4'h0;
			done_reg <= 1'b0;
		end else if (i_ce) begin
			done_reg <= 1'b0;
			if (i_instr_start) begin
				left_reg <= clamp_cycles(i_instr_cycles);
			end else if (cycle_end && o_cpu_clk_en &&
					left_reg != 4'h0) begin
				left_reg <= left_reg - 4'h1;
				done_reg <= left_reg == 4'h1;
			end
		end
	end
	assign o_instr_done = done_reg;

	// **************************************************
	// operating mode machine
	// **************************************************
	mode_type ret_mode_reg; // mode to resume after stop
	logic base_timer_enable_bit_at_halt_reg; // timer enable captured at halt entry
	logic tap_prev_reg; // last base timer tap level
	logic tap; // tap chosen by the base timer clock select
	logic wake_service_reg;
	logic wake_resume_reg;
	logic latch_reg;
	logic service_reg;
	logic [4:0] tap_idx;
	logic warm_done;

	assign tap_idx = BT_TAP_BASE + {2'h0, bt_ctrl_reg[2:0]};
	assign tap = div_reg[tap_idx];
	assign warm_done = div_reg[20:6] >= WARM_UP_TICKS;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tap_prev_reg <= 1'b0;
		end else if (i_ce) begin
			tap_prev_reg <= tap;
		end
	end

	// mode transitions; reset lands in single clock run
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mode_reg <= single_clock_run;
			ret_mode_reg <= single_clock_run;
			warm_fast_reg <= 1'b0;
			base_timer_enable_bit_at_halt_reg <= 1'b0;
			wake_service_reg <= 1'b0;
			wake_resume_reg <= 1'b0;
			latch_reg <= 1'b0;
			service_reg <= 1'b0;
		end else if (i_ce) begin
			wake_service_reg <= 1'b0;
			wake_resume_reg <= 1'b0;
			latch_reg <= 1'b0;
			service_reg <= 1'b0;
			unique case (mode_reg)
				single_clock_run, dual_clock_fast_run, slow_dual_run: begin
					if (sysctl_one_reg[STOP_BIT]) begin
						mode_reg <= stop_hold;
						ret_mode_reg <= mode_reg;
						warm_fast_reg <= !slow_mode;
					end else if (sysctl_two_reg[HALT_BIT] &&
							mode_reg == single_clock_run) begin
						mode_reg <= single_clock_halt;
						base_timer_enable_bit_at_halt_reg <= bt_ctrl_reg[BASE_TIMER_ENABLE_BIT_BIT];
					end else if (sysctl_two_reg[IDLE_BIT] && !slow_mode) begin
						mode_reg <= slow_en ? dual_clock_fast_wait :
							single_clock_wait;
					end else if (slow_en && sysctl_two_reg[MAIN_CLOCK_SELECT_BIT]) begin
						mode_reg <= slow_dual_run;
					end else if (slow_en) begin
						mode_reg <= dual_clock_fast_run;
					end else begin
						mode_reg <= single_clock_run;
					end
				end
				single_clock_wait, dual_clock_fast_wait: begin
					if (i_irq_request) begin
						mode_reg <= (mode_reg == single_clock_wait) ?
							single_clock_run : dual_clock_fast_run;
						wake_service_reg <= i_interrupt_master_enable;
						wake_resume_reg <= !i_interrupt_master_enable;
					end
				end
				single_clock_halt: begin
					// exit does not look at the timer enable bit itself
					if (tap_prev_reg && !tap) begin
						mode_reg <= single_clock_run;
						latch_reg <= base_timer_enable_bit_at_halt_reg;
						service_reg <= base_timer_enable_bit_at_halt_reg &&
							i_interrupt_master_enable &&
							i_base_timer_irq_enable;
					end
				end
				stop_hold: begin
					if (stop_release) begin
						mode_reg <= stop_warm_up;
					end
				end
				stop_warm_up: begin
					if (warm_done) begin
						mode_reg <= ret_mode_reg;
					end
				end
			endcase
		end
	end

	// **************************************************
	// clock gates and oscillator drives
	// **************************************************
	assign o_cpu_clk_en = is_run(mode_reg) && main_tick;
	assign o_periph_clk_en = main_tick && mode_reg != single_clock_halt &&
		mode_reg != stop_hold && mode_reg != stop_warm_up;
	assign o_base_timer_clk_en = main_tick && fast_on;
	assign o_fast_osc_output = fast_on && !fast_sync_reg[1];
	assign o_slow_osc_output = slow_en && !slow_sync_reg[1];
	assign o_slow_pins_are_ports = !slow_en;
	assign o_wake_service = wake_service_reg;
	assign o_wake_resume = wake_resume_reg;
	assign o_base_timer_irq_latch = latch_reg;
	assign o_base_timer_irq_service = service_reg;

	// **************************************************
	// assertions
	// **************************************************
	a_reset_run: assert property (@(posedge i_mclk)
		$past(i_rst) && !i_rst |-> mode_reg == single_clock_run)
		else $error("mode after reset is not single run");
	a_stop_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg != $past(mode_reg) && $past(i_ce) &&
		(mode_reg == stop_hold || mode_reg == stop_warm_up)
		|-> div_reg == DIV_RESET && pre_reg == PRE_RESET)
		else $error("divider not cleared at stop");
	a_slow_stage: assert property (@(posedge i_mclk) disable iff (i_rst)
		slow_mode |-> st7_tick == slow_tick)
		else $error("slow mode stage seven source wrong");
	a_warm_stage: assert property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == stop_warm_up && warm_fast_reg |->
		st7_tick == carry6)
		else $error("warm-up stage seven source wrong");
	a_state_step: assert property (@(posedge i_mclk) disable iff (i_rst)
		main_tick && i_ce |=> state_reg == $past(state_reg) + 2'h1)
		else $error("machine state did not advance");
	a_wait_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == single_clock_wait && i_irq_request && i_ce
		|=> mode_reg == single_clock_run &&
		o_wake_service == $past(i_interrupt_master_enable))
		else $error("wait mode wake wrong");
	a_halt_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == single_clock_halt |->
		!o_cpu_clk_en && !o_periph_clk_en)
		else $error("clocks not gated in halt");
	a_halt_exit: assert property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == single_clock_halt && tap_prev_reg && !tap && i_ce
		|=> mode_reg == single_clock_run &&
		o_base_timer_irq_latch == $past(base_timer_enable_bit_at_halt_reg))
		else $error("halt exit wrong");
	a_clock_switch: assert property (@(posedge i_mclk) disable iff (i_rst)
		sel_slow_reg != $past(sel_slow_reg) |->
		state_reg == 2'h0)
		else $error("main clock switched mid cycle");
	c_halt_exit: cover property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == single_clock_halt ##1 mode_reg == single_clock_run);
	c_stop_cycle: cover property (@(posedge i_mclk) disable iff (i_rst)
		mode_reg == stop_warm_up ##1 is_run(mode_reg));
	c_slow_run: cover property (@(posedge i_mclk) disable iff (i_rst)
		sel_slow_reg && o_cpu_clk_en);
endmodule

//--- verif/tb_top.sv
// self-checking bench for the system clock and mode controller
// assumes the design package is compiled first; the bench drives
// oscillator pins, register port and interrupt lines by hand
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
	import sysclk_pkg::*;
	logic i_mclk;
	logic i_rst;
	logic i_ce; // dropped once to show that divider and machine state freeze
	bus_req_type i_bus;
	logic [7:0] o_rdata;
	logic fast_pin, slow_pin, stop_pin, irq, interrupt_master_enable, bt_ie;
	logic instr_start;
	logic [3:0] instr_cycles;
	logic fast_out, slow_out, pins_ports, cpu_en, per_en, bt_en;
	logic [1:0] mstate;
	logic instr_done, wake_svc, wake_res, bt_latch, bt_svc;
	logic [20:0] divider;
	logic [7:0] rd_val;
	int num_errors = 0;
	int checked = 0;
	int n_cpu, n_per, n_bt, n_svc, n_res, n_lat, n_bsvc, n_done;
	system_clock_mode_controller #(.WARM_UP_TICKS(15'h0004)) dut_u (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus),
		.o_rdata(o_rdata), .i_fast_osc_input(fast_pin),
		.i_slow_osc_input(slow_pin), .i_stop_pin(stop_pin),
		.i_irq_request(irq), .i_interrupt_master_enable(interrupt_master_enable),
		.i_base_timer_irq_enable(bt_ie), .i_instr_start(instr_start),
		.i_instr_cycles(instr_cycles), .o_fast_osc_output(fast_out),
		.o_slow_osc_output(slow_out), .o_slow_pins_are_ports(pins_ports),
		.o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
		.o_base_timer_clk_en(bt_en), .o_machine_state(mstate),
		.o_instr_done(instr_done), .o_divider(divider),
		.o_wake_service(wake_svc), .o_wake_resume(wake_res),
		.o_base_timer_irq_latch(bt_latch),
		.o_base_timer_irq_service(bt_svc)
	);
	// ************************************
	// clock, reset and pulse monitors
	// ************************************
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// counters of one-cycle pulses; tasks zero them before use
	always @(posedge i_mclk) begin
		if (!i_rst) begin
			n_cpu += int'(cpu_en === 1'b1);
			n_per += int'(per_en === 1'b1);
			n_bt += int'(bt_en === 1'b1);
			n_svc += int'(wake_svc === 1'b1);
			n_res += int'(wake_res === 1'b1);
			n_lat += int'(bt_latch === 1'b1);
			n_bsvc += int'(bt_svc === 1'b1);
			n_done += int'(instr_done === 1'b1);
		end
	end
	task automatic zero_counts();
		n_cpu = 0; n_per = 0; n_bt = 0; n_svc = 0;
		n_res = 0; n_lat = 0; n_bsvc = 0; n_done = 0;
	endtask
	// ************************************
	// register port and pin drivers
	// ************************************
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [1:0] a);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		#1 rd_val = o_rdata;
	endtask
	// fast or slow oscillator pulses; three cycles per level keeps the
	// synchroniser well ahead of the pin
	task automatic osc_pulses(input bit slow, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_mclk);
			if (slow) slow_pin <= 1'b1; else fast_pin <= 1'b1;
			repeat (3) @(posedge i_mclk);
			if (slow) slow_pin <= 1'b0; else fast_pin <= 1'b0;
			repeat (2) @(posedge i_mclk);
		end
		repeat (4) @(posedge i_mclk);
	endtask
	// ************************************
	// scenarios
	// ************************************
	task automatic t_reset_and_divider();
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h00)
		`CHK(pins_ports, 1'b1)
		`CHK(slow_out, 1'b0)
		`CHK(divider, 21'h00000)
		zero_counts();
		osc_pulses(1'b0, 42);
		`CHK(divider, 21'h00000a)
		`CHK(mstate, 2'h2)
		`CHK(n_cpu, 42)
		// with the enable low the pin pulses must leave no trace
		i_ce <= 1'b0;
		osc_pulses(1'b0, 2);
		`CHK(divider, 21'h00000a)
		`CHK(mstate, 2'h2)
		i_ce <= 1'b1;
	endtask
	task automatic t_instr();
		int cnt;
		@(posedge i_mclk);
		instr_cycles <= 4'h3;
		instr_start <= 1'b1;
		@(posedge i_mclk);
		instr_start <= 1'b0;
		zero_counts();
		for (cnt = 0; cnt < 20 && n_done == 0; cnt++) osc_pulses(1'b0, 1);
		`CHK(n_done, 1)
		`CHK(n_cpu > 8 && n_cpu <= 12, 1'b1)
	endtask
	task automatic t_wait(input logic m);
		wr_reg(SYSCTL_TWO_ADDR, 8'h10);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h01)
		zero_counts();
		interrupt_master_enable <= m;
		osc_pulses(1'b0, 8);
		`CHK(n_cpu, 0)
		`CHK(n_per, 8)
		irq <= 1'b1;
		repeat (3) @(posedge i_mclk);
		irq <= 1'b0;
		`CHK(n_svc, int'(m))
		`CHK(n_res, int'(!m))
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h00)
	endtask
	// halt exits on the falling edge of stage nine, so roughly
	// two thousand fast ticks pass before the wake
	task automatic t_halt();
		int cnt;
		interrupt_master_enable <= 1'b1;
		bt_ie <= 1'b1;
		wr_reg(BT_CTRL_ADDR, 8'h08);
		wr_reg(SYSCTL_TWO_ADDR, 8'h04);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h02)
		zero_counts();
		for (cnt = 0; cnt < 2200 && n_lat == 0; cnt++) osc_pulses(1'b0, 1);
		`CHK(n_cpu, 0)
		`CHK(n_per, 0)
		`CHK(n_bt > 100, 1'b1)
		`CHK(divider[8], 1'b0)
		`CHK(n_lat, 1)
		`CHK(n_bsvc, 1)
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h00)
	endtask
	// stop from single run with level release: divider cleared on
	// entry and exit, warm-up counts stage six carries, then run
	task automatic t_stop();
		wr_reg(SYSCTL_ONE_ADDR, 8'hc0);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h06)
		`CHK(divider, 21'h00000)
		`CHK(fast_out, 1'b0)
		zero_counts();
		osc_pulses(1'b0, 4);
		`CHK(n_bt, 0)
		stop_pin <= 1'b1;
		repeat (4) @(posedge i_mclk);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h07)
		`CHK(divider, 21'h00000)
		osc_pulses(1'b0, 1100);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h00)
		`CHK(fast_out, 1'b1)
		stop_pin <= 1'b0;
	endtask
	task automatic t_dual();
		wr_reg(SYSCTL_TWO_ADDR, 8'h40);
		osc_pulses(1'b0, 4);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h03)
		`CHK(pins_ports, 1'b0)
		`CHK(slow_out, 1'b1)
		wr_reg(SYSCTL_TWO_ADDR, 8'h60);
		osc_pulses(1'b0, 4);
		osc_pulses(1'b1, 4);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h05)
		zero_counts();
		osc_pulses(1'b0, 8);
		`CHK(n_cpu, 0)
		osc_pulses(1'b1, 8);
		`CHK(n_cpu, 8)
		wr_reg(SYSCTL_TWO_ADDR, 8'h40);
		osc_pulses(1'b1, 4);
		osc_pulses(1'b0, 4);
		rd_reg(STATUS_ADDR);
		`CHK(rd_val, 8'h03)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// cuts a hang short well beyond the expected run length
	initial begin
		repeat (80000) @(posedge i_mclk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_bus = '{addr: 2'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		fast_pin = 1'b0; slow_pin = 1'b0; stop_pin = 1'b0;
		irq = 1'b0; interrupt_master_enable = 1'b0; bt_ie = 1'b0;
		instr_start = 1'b0;
		instr_cycles = 4'h0;
		zero_counts();
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_reset_and_divider();
		t_instr();
		t_wait(1'b1);
		t_wait(1'b0);
		t_halt();
		t_stop();
		t_dual();
		tally_and_finish();
	end
endmodule
